/* xcp_pkg.sv */
// Purpose: shared constants and types of the external clock prescaler
// Assumes: 32-bit classic Wishbone slave, byte addressed
// Notes: register offsets are byte addresses, one aligned word each
package xcp_pkg;
   // bus geometry
   localparam int XCP_ADR_W = 8;
   localparam logic [XCP_ADR_W-1:0] XCP_CTRL_OFS = 8'h00;
   localparam logic [XCP_ADR_W-1:0] XCP_STAT_OFS = 8'h04;

   // control register layout
   localparam int XCP_EN_BIT = 15;
   localparam int XCP_RIS_BIT = 8;
   localparam int XCP_DIV_MSB = 7;
   localparam int XCP_DIV_LSB = 0;
   localparam logic [15:0] XCP_CTRL_WMASK = 16'h81FF;
   localparam logic [7:0] XCP_DIV_RESET = 8'h07;
   localparam logic [15:0] XCP_CTRL_RESET = 16'h0007;

   // status register layout
   localparam int XCP_ST_RUN_BIT = 0;
   localparam int XCP_ST_LEVEL_BIT = 1;
   localparam int XCP_ST_PIN_BIT = 2;
   localparam int XCP_ST_SUSP_BIT = 3;
   localparam int XCP_ST_DIV_LSB = 8;

   // generator state
   typedef enum logic [0:0] {
      XCP_GEN_IDLE = 1'b0,
      XCP_GEN_RUN = 1'b1
   } xcp_gen_state_t;
endpackage

/* xcp_div_if.sv */
// Purpose: carrier between register side and clock generator
// Assumes: both ends on clk_sys
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface xcp_div_if;
   logic [7:0] divValue;
   logic wantRun;
   logic running;
   logic level;
   logic [7:0] activeDiv;
   modport ctrl (output divValue, output wantRun,
      input running, input level, input activeDiv);
   modport gen (input divValue, input wantRun,
      output running, output level, output activeDiv);
endinterface
`default_nettype wire

/* xcp_clock_gen.sv */
// Purpose: counter that turns clk_sys into the prescaled clock level
// Assumes: divValue and wantRun come from clk_sys logic
// Notes: ratio and run state only change at a period boundary
`timescale 1ns/1ps
`default_nettype none
module xcp_clock_gen
   import xcp_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // generator side of the carrier
   xcp_div_if.gen dv
);
   xcp_gen_state_t stateReg;
   logic [7:0] cntReg;
   logic [7:0] curDivReg;
   logic levelReg;
   logic atEnd;
   logic [7:0] cntNext;

   assign atEnd = (stateReg == XCP_GEN_RUN) && (cntReg == curDivReg);
   assign cntNext = cntReg + 8'h01;

   // one period is curDiv+1 counts; high for the first half, rounded up
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stateReg <= XCP_GEN_IDLE;
         cntReg <= 8'h00;
         curDivReg <= XCP_DIV_RESET;
         levelReg <= 1'b0;
      end else begin
         unique case (stateReg)
            XCP_GEN_IDLE: begin
               // idle level is low, so starting never makes a short phase
               if (dv.wantRun) begin
                  stateReg <= XCP_GEN_RUN;
                  curDivReg <= dv.divValue;
                  cntReg <= 8'h00;
                  levelReg <= 1'b1;
               end
            end
            XCP_GEN_RUN: begin
               if (atEnd) begin
                  cntReg <= 8'h00;
                  if (dv.wantRun) begin
                     curDivReg <= dv.divValue;
                     // divide by one can only toggle at clk_sys rate
                     levelReg <= (dv.divValue == 8'h00) ? ~levelReg
                                                        : 1'b1;
                  end else begin
                     stateReg <= XCP_GEN_IDLE;
                     levelReg <= 1'b0;
                  end
               end else begin
                  cntReg <= cntNext;
                  levelReg <= (cntNext <= (curDivReg >> 1));
               end
            end
         endcase
      end
   end

   assign dv.running = (stateReg == XCP_GEN_RUN);
   assign dv.level = levelReg;
   assign dv.activeDiv = curDivReg;
endmodule
`default_nettype wire

/* xcp_prescaler.sv */
// What this block does
// - output clock is clk_sys divided by divider_value plus one
// - divider codes 0x01 to 0xFF give ratios 2 to 256; code 0x00 also gives ratio 2
// - divider_value resets to 0x07, dividing by eight
// - a counter of clk_sys edges marks each output clock edge
// - a new divider_value takes effect only after the current period
// - with prescale_out_enable set the pin carries the clock, except in suspend without run_in_suspend
// - with it clear the pin follows gpio_direction and gpio_data_out
// - standby or halt stops clk_sys, so the output stops too
// - control contents survive standby and halt without reprogramming
// - control writes are still taken while in debug suspend
// - in suspend the clock runs only if run_in_suspend and enable set
// - writes to bits 14 to 9 are ignored
// - reads in any mode, writes only from privileged accesses
// - 16-bit and 32-bit writes to control are both accepted
//
// Purpose: external clock prescaler with gpio pin mux, Wishbone slave
// Assumes: gpio and suspend inputs come from clk_sys logic
// Notes: pin outputs lag the generator by one registered stage
`timescale 1ns/1ps
`default_nettype none
module xcp_prescaler
   import xcp_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // classic Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [xcp_pkg::XCP_ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // access and mode qualifiers
   input wire logic privileged,
   input wire logic debugSuspend,
   // gpio side of the pin mux
   input wire logic gpioDirection,
   input wire logic gpioDataOut,
   output logic gpioPinIn,
   // shared pin, split into in, out, enable
   input wire logic sharedGpioPinIn,
   output logic sharedGpioPinOut,
   output logic sharedGpioPinOe
);
   import xcp_pkg::*;

   xcp_div_if dv ();

   logic [15:0] ctrlReg;
   logic [15:0] ctrlNext;
   logic ackReg;
   logic [31:0] datReg;
   logic [31:0] datNext;
   logic pinOutReg;
   logic pinOeReg;
   logic pinMetaReg;
   logic pinSyncReg;
   logic request;
   logic writeCommit;
   logic prescaleOutEnable;
   logic runInSuspend;
   logic [7:0] dividerValue;
   logic [15:0] laneMask;
   logic [31:0] statusWord;

   assign prescaleOutEnable = ctrlReg[XCP_EN_BIT];
   assign runInSuspend = ctrlReg[XCP_RIS_BIT];
   assign dividerValue = ctrlReg[XCP_DIV_MSB:XCP_DIV_LSB];

   // bus handshake: ack one cycle after the request, one cycle wide
   assign request = cyc_i && stb_i;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ackReg <= 1'b0;
      end else begin
         ackReg <= request && !ackReg;
      end
   end

   // write lands on the edge where the master sees ack
   assign writeCommit = request && we_i && ackReg &&
                        (adr_i == XCP_CTRL_OFS) && privileged;

   // byte lanes 0 and 1 hold the register, so halfword writes work
   assign laneMask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

   always_comb begin
      ctrlNext = ctrlReg;
      if (writeCommit) begin
         // reserved bits stay zero whatever is written
         ctrlNext = (ctrlReg & ~(laneMask & XCP_CTRL_WMASK)) |
                    (dat_i[15:0] & laneMask & XCP_CTRL_WMASK);
      end
   end

   // no low-power input: clk_sys simply stops, flops hold their state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrlReg <= XCP_CTRL_RESET;
      end else begin
         ctrlReg <= ctrlNext;
      end
   end

   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[XCP_ST_RUN_BIT] = dv.running;
      statusWord[XCP_ST_LEVEL_BIT] = dv.level;
      statusWord[XCP_ST_PIN_BIT] = pinSyncReg;
      statusWord[XCP_ST_SUSP_BIT] = debugSuspend;
      statusWord[XCP_ST_DIV_LSB +: 8] = dv.activeDiv;
   end

   // read data: unmapped offsets answer with zero
   always_comb begin
      datNext = 32'h0000_0000;
      if (adr_i == XCP_CTRL_OFS) begin
         datNext = {16'h0000, ctrlReg};
      end else if (adr_i == XCP_STAT_OFS) begin
         datNext = statusWord;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         datReg <= 32'h0000_0000;
      end else if (request && !ackReg) begin
         datReg <= datNext;
      end
   end

   // suspend gating decided here, applied by the generator at a boundary
   assign dv.divValue = dividerValue;
   assign dv.wantRun = prescaleOutEnable &&
                       !(debugSuspend && !runInSuspend);

   xcp_clock_gen u_gen (
      .clk_sys (clk_sys),
      .rst (rst),
      .dv (dv)
   );

   // pin mux; generator stays selected until its last low phase ends
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pinOutReg <= 1'b0;
         pinOeReg <= 1'b0;
      end else if (dv.running) begin
         pinOutReg <= dv.level;
         pinOeReg <= 1'b1;
      end else begin
         pinOutReg <= gpioDataOut;
         pinOeReg <= gpioDirection;
      end
   end

   // pin input is asynchronous to clk_sys
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pinMetaReg <= 1'b0;
         pinSyncReg <= 1'b0;
      end else begin
         pinMetaReg <= sharedGpioPinIn;
         pinSyncReg <= pinMetaReg;
      end
   end

   assign dat_o = datReg;
   assign ack_o = ackReg;
   assign gpioPinIn = pinSyncReg;
   assign sharedGpioPinOut = pinOutReg;
   assign sharedGpioPinOe = pinOeReg;
endmodule
`default_nettype wire

/* xcp_monitor.sv */
// Purpose: port assertions for xcp_prescaler
// Assumes: shadow of control follows bus commits
// Notes: 300-cycle windows outlast the longest period
`timescale 1ns/1ps
`default_nettype none
module xcp_monitor
   import xcp_pkg::*;
(
   // every port of the prescaler
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [xcp_pkg::XCP_ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic privileged,
   input wire logic debugSuspend,
   input wire logic gpioDirection,
   input wire logic gpioDataOut,
   input wire logic gpioPinIn,
   input wire logic sharedGpioPinIn,
   input wire logic sharedGpioPinOut,
   input wire logic sharedGpioPinOe
);
   logic [15:0] ctl_reg, wMask;
   logic [8:0] idle_reg, run_reg;
   logic [1:0] up_reg;
   logic wantRun, commit;
   assign commit = cyc_i && stb_i && we_i && ack_o && privileged
      && adr_i == XCP_CTRL_OFS;
   assign wMask = XCP_CTRL_WMASK & {{8{sel_i[1]}}, {8{sel_i[0]}}};
   assign wantRun = ctl_reg[15] && !(debugSuspend && !ctl_reg[8]);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctl_reg <= XCP_CTRL_RESET;
      end else if (commit) begin
         ctl_reg <= (ctl_reg & ~wMask) | (dat_i[15:0] & wMask);
      end
   end
   // generator idle after reset, so idle starts saturated
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         idle_reg <= 9'h12C;
         run_reg <= 9'h000;
         up_reg <= 2'h0;
      end else begin
         idle_reg <= wantRun ? 9'h000 : idle_reg + {8'h00, idle_reg < 9'h12C};
         run_reg <= !wantRun ? 9'h000 : run_reg + {8'h00, run_reg < 9'h12C};
         up_reg <= up_reg + {1'h0, up_reg != 2'h3};
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acked next cycle");
   chk_read_value: assert property
      (ack_o && !we_i && adr_i == XCP_CTRL_OFS |-> dat_o[15:0] == ctl_reg)
      else $error("control read mismatch");
   chk_sync_pin: assert property
      (up_reg == 2'h3 |-> gpioPinIn == $past(sharedGpioPinIn, 2))
      else $error("pin input not two flops late");
   chk_gpio_mux: assert property (idle_reg == 9'h12C |->
      sharedGpioPinOe == $past(gpioDirection)
      && sharedGpioPinOut == $past(gpioDataOut))
      else $error("pin not with gpio");
   chk_clock_runs: assert property
      (run_reg == 9'h12C |-> sharedGpioPinOe)
      else $error("pin not driven while running");
   chk_start_high: assert property
      ($rose(sharedGpioPinOe) && run_reg != 9'h000 |-> sharedGpioPinOut)
      else $error("clock starts low");
   chk_stop_low: assert property
      ($fell(sharedGpioPinOe) && idle_reg != 9'h12C
      |-> !$past(sharedGpioPinOut))
      else $error("high phase cut on stop");
   cover property (commit);
   cover property ($rose(sharedGpioPinOe) && run_reg != 9'h000);
   cover property (debugSuspend && run_reg == 9'h12C);
endmodule
`default_nettype wire

/* xcp_board_model.sv */
// Purpose: board side of the shared pin
// Assumes: pull-up resistor on the pin
// Notes: a released pin reads high
`timescale 1ns/1ps
`default_nettype none
module xcp_board_model (
   // pin from the device and level on the board
   input wire logic pinOut,
   input wire logic pinOe,
   output logic pinLevel
);
   assign pinLevel = pinOe ? pinOut : 1'b1;
endmodule
`default_nettype wire

/* xcp_prescaler_bench.sv */
// Purpose: random and corner tests of the prescaler
// Assumes: xorshift seed 85200
// Notes: code 0x00 not timed, it toggles on every clk_sys cycle
`timescale 1ns/1ps
`default_nettype none
module xcp_prescaler_bench;
   import xcp_pkg::*;
   logic clk_sys, rst, cyc, stb, we, priv, susp, gDir, gDout;
   logic ack, pinIn, pinOut, pinOe, level;
   logic [7:0] adr, dv;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, dato, seed;
   int num_errors, check_count;
   xcp_prescaler dut_u (.clk_sys(clk_sys), .rst(rst), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(dato), .ack_o(ack), .privileged(priv), .debugSuspend(susp),
      .gpioDirection(gDir), .gpioDataOut(gDout), .gpioPinIn(pinIn),
      .sharedGpioPinIn(level), .sharedGpioPinOut(pinOut),
      .sharedGpioPinOe(pinOe));
   xcp_board_model board_u (.pinOut(pinOut), .pinOe(pinOe),
      .pinLevel(level));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   task automatic finish_test();
      if (num_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [3:0] s, input logic [31:0] d, input logic p);
      int n = 0;
      @(posedge clk_sys);
      {cyc, stb, we, adr, sel, wdat, priv} <= {2'h3, w, a, s, d, p};
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rdat = dato;
      {cyc, stb, we} <= 3'h0;
      if (n >= 20) begin
         num_errors++;
         finish_test();
      end
   endtask
   // times one whole period of the board level
   task automatic measure(input logic [7:0] d);
      int n = 0;
      int hi = 0;
      int lo = 0;
      while (level !== 1'b0 && n < 999) begin @(posedge clk_sys); n++; end
      while (level !== 1'b1 && n < 999) begin @(posedge clk_sys); n++; end
      while (level === 1'b1 && n < 999) begin
         @(posedge clk_sys);
         n++;
         hi++;
      end
      while (level === 1'b0 && n < 999) begin
         @(posedge clk_sys);
         n++;
         lo++;
      end
      if (n >= 999) begin
         num_errors++;
         finish_test();
      end
      check(hi, d / 2 + 1);
      check(hi + lo, d + 1);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      {cyc, stb, we, adr, sel, wdat, priv, susp, gDir, gDout} = '0;
      {num_errors, check_count, rst, seed} = {64'h0, 1'h1, 32'h14CD0};
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      bus(1'h0, XCP_CTRL_OFS, 4'hF, 32'h0, 1'h0);
      check(rdat[15:0], 16'h0007);
      bus(1'h0, 8'h10, 4'hF, 32'h0, 1'h1);
      check(rdat, 32'h0);
      bus(1'h1, XCP_CTRL_OFS, 4'hF, 32'hFFFF, 1'h0);
      bus(1'h1, XCP_CTRL_OFS, 4'h3, 32'h7E03, 1'h1);
      bus(1'h0, XCP_CTRL_OFS, 4'hF, 32'h0, 1'h0);
      check(rdat[15:0], 16'h0003);
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         dv = i == 0 ? 8'h01 : i == 1 ? 8'hFF : seed[7:0] | 8'h01;
         bus(1'h1, XCP_CTRL_OFS, {{2{i[0]}}, 2'h0} | 4'h3,
            {seed[31:16], 8'h80, dv}, 1'h1);
         bus(1'h0, XCP_CTRL_OFS, 4'hF, 32'h0, 1'h1);
         check(rdat[15:0], {8'h80, dv});
         measure(dv);
      end
      bus(1'h1, XCP_CTRL_OFS, 4'h3, 32'h8107, 1'h1);
      susp <= 1'b1;
      measure(8'h07);
      bus(1'h1, XCP_CTRL_OFS, 4'h3, 32'h8003, 1'h1);
      bus(1'h0, XCP_CTRL_OFS, 4'hF, 32'h0, 1'h1);
      check(rdat[15:0], 16'h8003);
      repeat (320) @(posedge clk_sys);
      check(pinOe, 1'b0);
      susp <= 1'b0;
      measure(8'h03);
      bus(1'h1, XCP_CTRL_OFS, 4'h3, 32'h0005, 1'h1);
      repeat (320) @(posedge clk_sys);
      repeat (200) begin
         @(posedge clk_sys);
         seed = xs(seed);
         {gDir, gDout} <= seed[1:0];
      end
      {gDir, gDout} <= 2'h3;
      repeat (3) @(posedge clk_sys);
      check({pinOe, pinOut}, 2'h3);
      bus(1'h1, XCP_CTRL_OFS, 4'h3, 32'h8005, 1'h1);
      measure(8'h05);
      finish_test();
   end
endmodule
bind xcp_prescaler xcp_monitor mon_u (.*);
`default_nettype wire
